// ---- shared/rpo_pkg.sv ----
// Constants and types shared by the ramped pulse output block
package rpo_pkg;
    // Parameter table word indices, relative to the base pointer
    localparam logic [3:0] RPO_IDX_START = 4'h0;
    localparam logic [3:0] RPO_IDX_GAP = 4'h1;
    localparam logic [3:0] RPO_IDX_TARGET = 4'h2;
    localparam logic [3:0] RPO_IDX_TOTAL_LO = 4'h3;
    localparam logic [3:0] RPO_IDX_TOTAL_HI = 4'h4;
    localparam logic [3:0] RPO_IDX_RAMP_LO = 4'h5;
    localparam logic [3:0] RPO_IDX_RAMP_HI = 4'h6;
    // Byte addresses: table memory is word i at 4*i, control block above it
    localparam logic [7:0] RPO_MEM_LAST = 8'h3C;
    localparam logic [7:0] RPO_ADDR_BASE = 8'h80;
    localparam logic [7:0] RPO_ADDR_CTRL = 8'h84;
    localparam logic [7:0] RPO_ADDR_FLAGS = 8'h88;
    localparam logic [7:0] RPO_ADDR_IRQ_STAT = 8'h8C;
    localparam logic [7:0] RPO_ADDR_IRQ_MASK = 8'h90;
    // Reset values, clock frequency and divider cycle count
    localparam logic [3:0] RPO_BASE_RESET = 4'h0;
    localparam logic [3:0] RPO_FLAGS_RESET = 4'h0;
    localparam logic [31:0] RPO_CLK_HZ = 32'h05F5_E100;
    localparam int RPO_DIV_CYCLES = 32;
    // Status flags, also the layout of the interrupt status and mask
    typedef struct packed {
        logic done;
        logic decel;
        logic target;
        logic accel;
    } rpo_flags_t;
    // AHB-Lite address phase captured for the data phase
    typedef struct packed {
        logic write;
        logic [7:0] addr;
    } rpo_ahb_req_t;
    typedef enum logic [1:0] {
        RPO_PH_ACC = 2'b00,
        RPO_PH_HOLD = 2'b01,
        RPO_PH_DEC = 2'b10
    } rpo_phase_t;
    typedef enum logic [2:0] {
        RPO_ST_IDLE = 3'b000,
        RPO_ST_SECTIONS = 3'b001,
        RPO_ST_SHARE = 3'b010,
        RPO_ST_PERIOD = 3'b011,
        RPO_ST_OUTPUT = 3'b100,
        RPO_ST_DONE = 3'b101
    } rpo_state_t;
endpackage

// ---- hdl/rpo_div.sv ----
// Sequential restoring divider shared by the ramp sequencer
`timescale 1ns/10ps
module rpo_div #(
    parameter int WIDTH = 32
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Request
    input wire logic start,
    input wire logic [WIDTH-1:0] dividend,
    input wire logic [WIDTH-1:0] divisor,
    // Result
    output logic done,
    output logic [WIDTH-1:0] quotient,
    output logic [WIDTH-1:0] remainder
);
    logic [WIDTH-1:0] dvs;
    logic [$clog2(WIDTH+1)-1:0] count;
    logic busy;
    wire logic [WIDTH:0] trial = {remainder, quotient[WIDTH-1]};
    wire logic fits = trial >= {1'b0, dvs};

    // Division by zero gives an all-ones quotient, which reads as a very long period
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dvs <= '0;
            count <= '0;
            busy <= 1'b0;
            done <= 1'b0;
            quotient <= '0;
            remainder <= '0;
        end else begin
            done <= 1'b0;
            if (start) begin
                dvs <= divisor;
                quotient <= dividend;
                remainder <= '0;
                count <= ($clog2(WIDTH+1))'(WIDTH);
                busy <= 1'b1;
            end else if (busy) begin
                remainder <= fits ? trial[WIDTH-1:0] - dvs : trial[WIDTH-1:0];
                quotient <= {quotient[WIDTH-2:0], fits};
                count <= count - 1'b1;
                if (count == 1) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
            end
        end
    end
endmodule

// ---- hdl/rpo_top.sv ----
// Ramped pulse train generator with its AHB-Lite register slave
//
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/10ps
// Functional notes
// (RL1) Load table, set switch in run; runs alone
// (RL2) Four flags show current ramp phase
// (RL3) Start, gap, target at words 0..2
// (RL4) Total pulses from words 3 and 4
// (RL5) Ramp pulses from words 5 and 6
// (RL6) Ramp train drives only first pulse pin
// (RL7) Start below target, gap within difference
// (RL8) Total over twice ramp, ramp over sections
// (RL9) Frequencies between 25 Hz and 10 kHz
// (RL10) Switch off clears done, keeps others
// (RL11) Stop to run clears switch, flags
// (RL12) Ramp or plain pulse train, never both
// (RL13) Sections equal span over gap; equal share
// (RL14) Section n runs start plus n-1 gaps
// (RL15) Flags set per accel, target, decel, done
// (RL16) Software clears the switch, not hardware
// (RL17) Decel steps down with same section share
module rpo_top #(
    parameter int MEM_DEPTH = 16,
    parameter logic [31:0] CLK_HZ = rpo_pkg::RPO_CLK_HZ
) (
    // AHB-Lite slave
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Controller mode and plain pulse train instruction
    input wire logic run_mode,
    input wire logic plain_pulse_train_busy,
    input wire logic plain_pulse_train_level,
    // Outputs
    output logic first_pulse_output_pin,
    output logic irq
);
    import rpo_pkg::*;

    logic [15:0] table_mem [MEM_DEPTH];
    logic [3:0] parameter_table_base;
    logic ramp_activation_switch;
    rpo_flags_t flags;
    rpo_flags_t irq_stat;
    rpo_flags_t irq_mask;
    rpo_ahb_req_t dreq;
    logic dvalid;
    logic [1:0] run_sync;
    logic [1:0] busy_sync;
    logic [1:0] plain_sync;
    logic run_prev;
    logic switch_prev;
    rpo_state_t state;
    rpo_phase_t phase;
    logic [15:0] gap;
    logic [15:0] target;
    logic [15:0] freq;
    logic [15:0] top_freq;
    logic [31:0] total;
    logic [31:0] ramp;
    logic [31:0] sections;
    logic [31:0] share;
    logic [31:0] hold_pulses;
    logic [31:0] sec_idx;
    logic [31:0] period;
    logic [31:0] cyc;
    logic [31:0] pulses_left;
    logic div_start;
    logic [31:0] div_a;
    logic [31:0] div_b;
    logic div_done;
    logic [31:0] div_q;
    logic [31:0] div_r;

    function automatic logic [15:0] tword(input logic [3:0] base, input logic [3:0] idx,
                                          input logic [15:0] mem [MEM_DEPTH]);
        logic [3:0] a;
        a = base + idx;
        return mem[a];
    endfunction

    // Bus decode
    wire logic addr_phase = hsel && htrans[1] && hready;
    wire logic wr = dvalid && dreq.write;
    wire logic is_mem = dreq.addr <= RPO_MEM_LAST;
    wire logic [3:0] mem_idx = dreq.addr[5:2];
    wire logic wr_base = wr && dreq.addr == RPO_ADDR_BASE;
    wire logic wr_ctrl = wr && dreq.addr == RPO_ADDR_CTRL;
    wire logic wr_stat = wr && dreq.addr == RPO_ADDR_IRQ_STAT;
    wire logic wr_mask = wr && dreq.addr == RPO_ADDR_IRQ_MASK;
    wire logic [7:0] raddr = haddr[7:0];
    wire logic [31:0] rd_value =
        (raddr <= RPO_MEM_LAST && raddr[1:0] == 2'h0) ? {16'h0000, table_mem[raddr[5:2]]} :
        (raddr == RPO_ADDR_BASE) ? {28'h000_0000, parameter_table_base} :
        (raddr == RPO_ADDR_CTRL) ? {31'h0000_0000, ramp_activation_switch} :
        (raddr == RPO_ADDR_FLAGS) ? {28'h000_0000, flags} :
        (raddr == RPO_ADDR_IRQ_STAT) ? {28'h000_0000, irq_stat} :
        (raddr == RPO_ADDR_IRQ_MASK) ? {28'h000_0000, irq_mask} : 32'h0000_0000;

    // Mode and pin events
    wire logic run_enter = run_sync[1] && !run_prev;
    wire logic plain_busy = busy_sync[1];
    wire logic switch_fall = switch_prev && !ramp_activation_switch;
    wire logic go = ramp_activation_switch && !switch_prev && run_sync[1] && !plain_busy;
    wire logic period_end = state == RPO_ST_OUTPUT && cyc == period - 1;
    wire logic last_pulse = period_end && pulses_left == 32'h0000_0001;
    wire logic more_sections = sec_idx < sections;

    // Events raise sticky interrupt bits
    rpo_flags_t ev;
    assign ev.accel = state == RPO_ST_SHARE && div_done;
    assign ev.target = last_pulse && phase == RPO_PH_ACC && !more_sections;
    assign ev.decel = last_pulse && phase == RPO_PH_HOLD;
    assign ev.done = last_pulse && phase == RPO_PH_DEC && !more_sections;

    rpo_div #(
        .WIDTH(32)
    ) u_div (
        .hclk(hclk),
        .hresetn(hresetn),
        .start(div_start),
        .dividend(div_a),
        .divisor(div_b),
        .done(div_done),
        .quotient(div_q),
        .remainder(div_r)
    );

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run_sync <= 2'b00;
            busy_sync <= 2'b00;
            plain_sync <= 2'b00;
            run_prev <= 1'b0;
        end else begin
            run_sync <= {run_sync[0], run_mode};
            busy_sync <= {busy_sync[0], plain_pulse_train_busy};
            plain_sync <= {plain_sync[0], plain_pulse_train_level};
            run_prev <= run_sync[1];
        end
    end

    // AHB-Lite slave: zero wait states, OKAY always, unmapped reads zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h0000_0000;
            dvalid <= 1'b0;
            dreq <= '0;
        end else begin
            dvalid <= addr_phase;
            dreq <= '{write: hwrite, addr: haddr[7:0]};
            if (addr_phase && !hwrite) begin
                hrdata <= rd_value;
            end
        end
    end

    always_ff @(posedge hclk) begin
        if (wr && is_mem && dreq.addr[1:0] == 2'h0) begin
            table_mem[mem_idx] <= hwdata[15:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            parameter_table_base <= RPO_BASE_RESET;
            irq_mask <= RPO_FLAGS_RESET;
            irq_stat <= RPO_FLAGS_RESET;
            irq <= 1'b0;
            ramp_activation_switch <= 1'b0;
            switch_prev <= 1'b0;
        end else begin
            if (wr_base) begin
                parameter_table_base <= hwdata[3:0];
            end
            if (wr_mask) begin
                irq_mask <= hwdata[3:0];
            end
            // A new event wins over a write-one-to-clear in the same cycle
            irq_stat <= (irq_stat & ~(wr_stat ? rpo_flags_t'(hwdata[3:0]) : rpo_flags_t'(4'h0))) | ev;
            irq <= |(irq_stat & irq_mask);
            switch_prev <= ramp_activation_switch;
            if (run_enter) begin
                ramp_activation_switch <= 1'b0; // RL11
            end else if (wr_ctrl && (run_sync[1] || !hwdata[0])) begin
                ramp_activation_switch <= hwdata[0]; // RL1 RL16
            end
        end
    end

    // Ramp sequencer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= RPO_ST_IDLE;
            phase <= RPO_PH_ACC;
            flags <= RPO_FLAGS_RESET;
            gap <= 16'h0000;
            target <= 16'h0000;
            freq <= 16'h0000;
            top_freq <= 16'h0000;
            total <= 32'h0000_0000;
            ramp <= 32'h0000_0000;
            sections <= 32'h0000_0000;
            share <= 32'h0000_0000;
            hold_pulses <= 32'h0000_0000;
            sec_idx <= 32'h0000_0000;
            period <= 32'h0000_0000;
            cyc <= 32'h0000_0000;
            pulses_left <= 32'h0000_0000;
            div_start <= 1'b0;
            div_a <= 32'h0000_0000;
            div_b <= 32'h0000_0000;
            first_pulse_output_pin <= 1'b0;
        end else begin
            div_start <= 1'b0;
            if (run_enter) begin
                state <= RPO_ST_IDLE;
                flags <= RPO_FLAGS_RESET; // RL11
            end else if (switch_fall) begin
                state <= RPO_ST_IDLE;
                flags.done <= 1'b0; // RL10
            end else begin
                unique case (state)
                    RPO_ST_IDLE: begin
                        if (go) begin
                            freq <= tword(parameter_table_base, RPO_IDX_START, table_mem); // RL3
                            gap <= tword(parameter_table_base, RPO_IDX_GAP, table_mem); // RL3
                            target <= tword(parameter_table_base, RPO_IDX_TARGET, table_mem); // RL3
                            total <= {tword(parameter_table_base, RPO_IDX_TOTAL_HI, table_mem),
                                      tword(parameter_table_base, RPO_IDX_TOTAL_LO, table_mem)}; // RL4
                            ramp <= {tword(parameter_table_base, RPO_IDX_RAMP_HI, table_mem),
                                     tword(parameter_table_base, RPO_IDX_RAMP_LO, table_mem)}; // RL5
                            div_a <= {16'h0000, tword(parameter_table_base, RPO_IDX_TARGET, table_mem)
                                      - tword(parameter_table_base, RPO_IDX_START, table_mem)}; // RL13
                            div_b <= {16'h0000, tword(parameter_table_base, RPO_IDX_GAP, table_mem)};
                            div_start <= 1'b1;
                            flags <= RPO_FLAGS_RESET;
                            state <= RPO_ST_SECTIONS;
                        end
                    end
                    RPO_ST_SECTIONS: begin
                        if (div_done) begin
                            sections <= div_q;
                            div_a <= ramp;
                            div_b <= div_q; // RL13
                            div_start <= 1'b1;
                            state <= RPO_ST_SHARE;
                        end
                    end
                    RPO_ST_SHARE: begin
                        if (div_done) begin
                            share <= div_q; // RL13
                            // Hold takes whatever the equal shares leave over
                            hold_pulses <= total - ((ramp - div_r) << 1);
                            phase <= RPO_PH_ACC;
                            sec_idx <= 32'h0000_0001;
                            flags.accel <= 1'b1; // RL15 RL2
                            div_a <= CLK_HZ;
                            div_b <= {16'h0000, freq};
                            div_start <= 1'b1;
                            state <= RPO_ST_PERIOD;
                        end
                    end
                    RPO_ST_PERIOD: begin
                        if (div_done) begin
                            period <= div_q; // RL14
                            cyc <= 32'h0000_0000;
                            pulses_left <= phase == RPO_PH_HOLD ? hold_pulses : share;
                            state <= RPO_ST_OUTPUT;
                        end
                    end
                    RPO_ST_OUTPUT: begin
                        cyc <= period_end ? 32'h0000_0000 : cyc + 32'h0000_0001;
                        if (period_end) begin
                            pulses_left <= pulses_left - 32'h0000_0001;
                        end
                        if (last_pulse) begin
                            div_a <= CLK_HZ;
                            div_start <= 1'b1;
                            state <= RPO_ST_PERIOD;
                            if (phase == RPO_PH_ACC && more_sections) begin
                                sec_idx <= sec_idx + 32'h0000_0001;
                                freq <= freq + gap; // RL14
                                div_b <= {16'h0000, freq + gap};
                            end else if (phase == RPO_PH_ACC) begin
                                top_freq <= freq;
                                freq <= target;
                                div_b <= {16'h0000, target};
                                phase <= RPO_PH_HOLD;
                                flags.accel <= 1'b0; // RL15 RL2
                                flags.target <= 1'b1; // RL15
                            end else if (phase == RPO_PH_HOLD) begin
                                freq <= top_freq; // RL17
                                div_b <= {16'h0000, top_freq};
                                sec_idx <= 32'h0000_0001;
                                phase <= RPO_PH_DEC;
                                flags.target <= 1'b0; // RL2
                                flags.decel <= 1'b1; // RL15
                            end else if (more_sections) begin
                                sec_idx <= sec_idx + 32'h0000_0001;
                                freq <= freq - gap; // RL17
                                div_b <= {16'h0000, freq - gap};
                            end else begin
                                div_start <= 1'b0;
                                flags.decel <= 1'b0; // RL2
                                flags.done <= 1'b1; // RL15
                                state <= RPO_ST_DONE;
                            end
                        end
                    end
                    RPO_ST_DONE: begin
                        state <= RPO_ST_DONE;
                    end
                    default: begin
                        state <= RPO_ST_IDLE;
                    end
                endcase
            end
            // Ramp owns the pin while busy, otherwise the plain train passes through
            if (state == RPO_ST_OUTPUT) begin
                first_pulse_output_pin <= cyc < (period >> 1); // RL6 RL12
            end else if (state == RPO_ST_IDLE || state == RPO_ST_DONE) begin
                first_pulse_output_pin <= plain_sync[1]; // RL12
            end else begin
                first_pulse_output_pin <= 1'b0;
            end
        end
    end
endmodule

// ---- bench/rpo_top_sva.sv ----
// Port-level assertions for the ramped pulse output block
`timescale 1ns/10ps
module rpo_top_sva #(
    parameter logic [31:0] CLK_HZ = 32'h0001_86A0
) (
    // Bus side
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    // Mode and pin side
    input wire logic run_mode,
    input wire logic plain_pulse_train_busy,
    input wire logic first_pulse_output_pin,
    input wire logic irq
);
    import rpo_pkg::*;
    // High time bounds at the legal 10 kHz and 25 Hz ends
    localparam int MIN_HIGH = int'(CLK_HZ / 32'd10000) / 2;
    localparam int MAX_HIGH = int'(CLK_HZ / 32'd25) / 2;
    logic [15:0] high_len;
    logic [3:0] quiet;
    wire addr_taken = hsel && htrans[1] && hready;
    // Plain pulses are excluded until the pin has been ours for a while
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            high_len <= 16'h0000;
            quiet <= 4'h0;
        end else begin
            high_len <= first_pulse_output_pin ? high_len + 16'h0001 : 16'h0000;
            quiet <= plain_pulse_train_busy ? 4'h0 : ((quiet == 4'hF) ? quiet : quiet + 4'h1);
        end
    end
    sequence s_read(logic [7:0] a);
        addr_taken && !hwrite && haddr[7:0] == a;
    endsequence
    sequence s_write(logic [7:0] a);
        addr_taken && hwrite && haddr[7:0] == a;
    endsequence
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    ready_always_a: assert property (hreadyout) else $error("hreadyout low");
    resp_okay_a: assert property (!hresp) else $error("error response");
    reset_idle_a: assert property ($rose(hresetn) |-> !first_pulse_output_pin && !irq)
        else $error("outputs not idle after reset");
    unmapped_zero_a: assert property (addr_taken && !hwrite && haddr[1:0] == 2'b00
        && haddr[7:0] inside {[8'h40:8'h7C], [8'h94:8'hFC]} |=> hrdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    ctrl_width_a: assert property (s_read(RPO_ADDR_CTRL) |=> hrdata[31:1] == 31'h0)
        else $error("switch read wider than one bit");
    flag_excl_a: assert property (s_read(RPO_ADDR_FLAGS) |=> hrdata[31:4] == 28'h0
        && !(hrdata[3] && hrdata[2]) && !(hrdata[2] && hrdata[1])) else $error("flags overlap");
    mask_quiet_a: assert property (s_write(RPO_ADDR_IRQ_MASK) ##1 hwdata[3:0] == 4'h0 |-> ##2 !irq)
        else $error("irq with all sources masked");
    pin_min_a: assert property ($fell(first_pulse_output_pin) && quiet == 4'hF |-> high_len >= 16'(MIN_HIGH))
        else $error("pulse high time too short");
    pin_max_a: assert property (first_pulse_output_pin && quiet == 4'hF |-> high_len <= 16'(MAX_HIGH))
        else $error("pulse high time too long");
endmodule

// ---- bench/rpo_drive_model.sv ----
// Behavioural stepper drive: counts pulses and records the high time of the first 64
`timescale 1ns/10ps
module rpo_drive_model (
    // Clock
    input wire logic hclk,
    // Pulse train and count clear
    input wire logic step_in,
    input wire logic clear
);
    int pulse_count = 0;
    int run_len = 0;
    int high_time [0:63];
    // A pulse is counted on its falling edge, once its width is known
    always @(posedge hclk) begin
        if (clear) begin
            pulse_count = 0;
            run_len = 0;
        end else if (step_in === 1'b1) begin
            run_len = run_len + 1;
        end else if (run_len != 0) begin
            if (pulse_count < 64) high_time[pulse_count] = run_len;
            pulse_count = pulse_count + 1;
            run_len = 0;
        end
    end
endmodule

// ---- bench/tb_top.sv ----
// Self-checking bench for the ramped pulse output block
`timescale 1ns/10ps
bind rpo_top rpo_top_sva #(.CLK_HZ(CLK_HZ)) rpo_top_sva_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
    .hready, .hreadyout, .hresp, .hrdata, .run_mode, .plain_pulse_train_busy, .first_pulse_output_pin, .irq);
module tb_top;
    import rpo_pkg::*;
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic [31:0] rdata;
    } rpo_row_t;
    // Reduced clock figure keeps section periods short
    localparam logic [31:0] TB_CLK_HZ = 32'h0001_86A0;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    logic run_mode = 1'b0;
    logic plain_busy = 1'b0;
    logic plain_level = 1'b0;
    logic model_clear = 1'b0;
    logic hreadyout, hresp, irq, pin;
    logic [31:0] hrdata, rd, keep;
    logic [3:0] seen;
    logic [31:0] exp_w [$];
    int err_count = 0;
    int samples_checked = 0;
    int sec, sh, f;
    rpo_row_t rows [8] = '{'{8'h00, 32'h0000_1234, 32'h0000_1234}, '{8'h18, 32'h0000_ABCD, 32'h0000_ABCD},
        '{8'h3C, 32'h0000_FFFF, 32'h0000_FFFF}, '{RPO_ADDR_BASE, 32'h0000_001F, 32'h0000_000F},
        '{RPO_ADDR_IRQ_MASK, 32'h0000_00FF, 32'h0000_000F}, '{RPO_ADDR_FLAGS, 32'h0000_000F, 32'h0000_0000},
        '{8'h40, 32'hFFFF_FFFF, 32'h0000_0000}, '{8'hA0, 32'hFFFF_FFFF, 32'h0000_0000}};
    // Start 1 kHz, gap 1 kHz, target 5 kHz, 20 pulses, 8 per ramp
    logic [15:0] prm [7] = '{16'h03E8, 16'h03E8, 16'h1388, 16'h0014, 16'h0000, 16'h0008, 16'h0000};
    rpo_top #(.MEM_DEPTH(16), .CLK_HZ(TB_CLK_HZ)) rpo_top_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .run_mode, .plain_pulse_train_busy(plain_busy),
        .plain_pulse_train_level(plain_level), .first_pulse_output_pin(pin), .irq);
    rpo_drive_model rpo_drive_model_i (.hclk, .step_in(pin), .clear(model_clear));
    initial begin
        forever #5 hclk = ~hclk;
    end
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic wait_flags(input logic [3:0] m);
        rd = 32'h0;
        for (int i = 0; i < 3000 && (rd[3:0] & m) == 4'h0; i++) begin
            bus(1'b0, RPO_ADDR_FLAGS, 32'h0, rd);
            seen = seen | rd[3:0];
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge hclk);
        err_count++;
        $display("mismatch at %0t: watchdog expired", $time);
        summarize();
    end
    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        run_mode <= 1'b1;
        repeat (6) @(posedge hclk);
        foreach (rows[i]) begin
            bus(1'b1, rows[i].addr, rows[i].wdata, rd);
            bus(1'b0, rows[i].addr, 32'h0, rd);
            chk(rd, rows[i].rdata, "register readback");
        end
        // Base 12 makes the table wrap past word 15
        bus(1'b1, RPO_ADDR_BASE, 32'h0000_000C, rd);
        for (int k = 0; k < 7; k++) bus(1'b1, {2'b00, 4'hC + 4'(k), 2'b00}, {16'h0000, prm[k]}, rd);
        bus(1'b1, RPO_ADDR_IRQ_MASK, 32'h0000_0000, rd);
        bus(1'b1, RPO_ADDR_IRQ_STAT, 32'h0000_000F, rd);
        model_clear <= 1'b1;
        @(posedge hclk);
        model_clear <= 1'b0;
        sec = (prm[2] - prm[0]) / prm[1];
        sh = {prm[6], prm[5]} / sec;
        for (int n = 0; n < 2 * sec; n++) begin
            f = (n < sec) ? prm[0] + n * prm[1] : prm[0] + (2 * sec - 1 - n) * prm[1];
            repeat (sh) exp_w.push_back((TB_CLK_HZ / f) / 2);
            if (n == sec - 1) repeat ({prm[4], prm[3]} - 2 * sec * sh) exp_w.push_back((TB_CLK_HZ / prm[2]) / 2);
        end
        seen = 4'h0;
        bus(1'b1, RPO_ADDR_CTRL, 32'h0000_0001, rd);
        wait_flags(4'h8);
        chk({28'h0, seen}, 32'h0000_000F, "phases seen");
        repeat (4) @(posedge hclk);
        chk(32'(rpo_drive_model_i.pulse_count), {prm[4], prm[3]}, "pulse total");
        foreach (exp_w[i]) chk(32'(rpo_drive_model_i.high_time[i]), exp_w[i], "high time");
        chk(32'(irq), 32'h0, "irq masked");
        bus(1'b0, RPO_ADDR_IRQ_STAT, 32'h0, rd);
        chk(rd, 32'hF, "event status");
        bus(1'b1, RPO_ADDR_IRQ_MASK, 32'hF, rd);
        repeat (3) @(posedge hclk);
        chk(32'(irq), 32'h1, "irq unmasked");
        bus(1'b0, RPO_ADDR_CTRL, 32'h0, rd);
        chk(rd, 32'h1, "switch held after done");
        bus(1'b0, RPO_ADDR_FLAGS, 32'h0, keep);
        bus(1'b1, RPO_ADDR_CTRL, 32'h0, rd);
        bus(1'b0, RPO_ADDR_FLAGS, 32'h0, rd);
        chk(rd, keep & 32'h7, "flags after switch off");
        bus(1'b1, RPO_ADDR_IRQ_STAT, 32'hF, rd);
        repeat (3) @(posedge hclk);
        chk(32'(irq), 32'h0, "irq cleared");
        // Abort in the gap before the first pulse, by a stop and run
        seen = 4'h0;
        bus(1'b1, RPO_ADDR_CTRL, 32'h1, rd);
        wait_flags(4'h1);
        run_mode <= 1'b0;
        repeat (5) @(posedge hclk);
        run_mode <= 1'b1;
        repeat (6) @(posedge hclk);
        bus(1'b0, RPO_ADDR_CTRL, 32'h0, rd);
        chk(rd, 32'h0, "switch after run entry");
        bus(1'b0, RPO_ADDR_FLAGS, 32'h0, rd);
        chk(rd, 32'h0, "flags after run entry");
        run_mode <= 1'b0;
        repeat (5) @(posedge hclk);
        bus(1'b1, RPO_ADDR_CTRL, 32'h1, rd);
        bus(1'b0, RPO_ADDR_CTRL, 32'h0, rd);
        chk(rd, 32'h0, "switch refused in stop");
        run_mode <= 1'b1;
        repeat (6) @(posedge hclk);
        plain_busy <= 1'b1;
        repeat (4) @(posedge hclk);
        bus(1'b1, RPO_ADDR_CTRL, 32'h1, rd);
        for (int i = 0; i < 4; i++) begin
            plain_level <= ~plain_level;
            repeat (5) @(posedge hclk);
            chk(32'(pin), 32'(plain_level), "pin follows plain train");
        end
        repeat (100) @(posedge hclk);
        bus(1'b0, RPO_ADDR_FLAGS, 32'h0, rd);
        chk(rd, 32'h0, "no ramp while plain owns pin");
        bus(1'b1, RPO_ADDR_CTRL, 32'h0, rd);
        plain_busy <= 1'b0;
        repeat (4) @(posedge hclk);
        summarize();
    end
endmodule
